// File: hw/rx_status.sv
// Receive status builder, status FIFO and AHB-Lite register slave
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module rx_status (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire rx_status_pkg::rx_in_s rx_in,
    input wire logic data_underrun,
    output rx_status_pkg::data_out_s data_out,
    output logic receiver_halted_interrupt,
    output logic receive_error_flag
);
    typedef struct packed {
        rx_status_pkg::rx_state_e fsm;
        logic [13:0] len;
        logic [15:0] ltype;
        logic bcast;
        logic mcast;
        logic late;
        logic rxer;
        logic crcb;
        logic filt;
        logic wd;
        logic [2:0] drib;
        logic m10;
        logic en;
        logic pbf;
        logic err;
        logic [3:0][31:0] sf;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] cnt;
        logic pend;
        logic pwr;
        logic [3:0] paddr;
        logic [31:0] rdata;
        logic [31:0] sword;
        logic dpush;
        logic [7:0] dbyte;
        logic drop;
        logic hirq;
    } st_s;

    st_s st_reg;
    st_s st_next;
    logic runt;
    logic push;
    logic pop;
    logic err_set;
    logic err_clr;
    logic [31:0] sw;

    assign hrdata = st_reg.rdata;
    assign hreadyout = !st_reg.pend;
    assign hresp = 1'b0;
    assign data_out.push = st_reg.dpush;
    assign data_out.data = st_reg.dbyte;
    assign data_out.drop = st_reg.drop;
    assign receiver_halted_interrupt = st_reg.hirq;
    assign receive_error_flag = st_reg.err;
    assign runt = sw[rx_status_pkg::SB_RUNT];

    // Status word assembled from the per-frame trackers; only complete in the status state
    always_comb begin
        logic rn;
        logic lc;
        logic w;
        logic lg;
        logic hdr;
        rn = st_reg.len < rx_status_pkg::LEN_RUNT;
        lc = st_reg.late;
        w = st_reg.wd;
        lg = st_reg.len > rx_status_pkg::LEN_MAX;
        hdr = st_reg.len >= rx_status_pkg::LEN_HDR;
        sw = '0;
        sw[rx_status_pkg::SB_FILT] = st_reg.filt;
        sw[rx_status_pkg::SB_LEN_LSB +: 14] = st_reg.len;
        sw[rx_status_pkg::SB_BC] = st_reg.bcast;
        sw[rx_status_pkg::SB_LE] = st_reg.len >= rx_status_pkg::LEN_OVH
            && st_reg.ltype <= rx_status_pkg::TYPE_MIN
            && st_reg.ltype != 16'(st_reg.len - rx_status_pkg::LEN_OVH);
        sw[rx_status_pkg::SB_RUNT] = rn;
        sw[rx_status_pkg::SB_MC] = st_reg.mcast;
        sw[rx_status_pkg::SB_LONG] = lg;
        sw[rx_status_pkg::SB_LATE] = lc;
        sw[rx_status_pkg::SB_TYPE] = hdr && st_reg.ltype > rx_status_pkg::TYPE_MIN;
        sw[rx_status_pkg::SB_WD] = w;
        sw[rx_status_pkg::SB_MII] = st_reg.rxer;
        sw[rx_status_pkg::SB_DRIB] = !lc && (st_reg.m10 ? st_reg.drib >= rx_status_pkg::DRIB_10M
            : st_reg.drib == rx_status_pkg::DRIB_MII);
        sw[rx_status_pkg::SB_CRC] = (st_reg.crcb || st_reg.rxer) && !rn && !lc && !w;
        sw[rx_status_pkg::SB_ES] = rn || lg || lc || sw[rx_status_pkg::SB_CRC];
    end

    always_comb begin
        logic acc;
        acc = hsel && hready && htrans == rx_status_pkg::HTRANS_NONSEQ && hsize == rx_status_pkg::HSIZE_WORD;
        st_next = st_reg;
        st_next.dpush = 1'b0;
        st_next.drop = 1'b0;
        st_next.hirq = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        err_set = data_underrun;
        err_clr = 1'b0;

        case (st_reg.fsm)
            rx_status_pkg::RX_IDLE: begin
                if (!st_reg.en) begin
                    st_next.fsm = rx_status_pkg::RX_HALT;
                    st_next.hirq = 1'b1;
                end else if (rx_in.sof) begin
                    st_next.fsm = rx_status_pkg::RX_RECV;
                    st_next.len = '0;
                    st_next.ltype = '0;
                    st_next.bcast = 1'b1;
                    st_next.mcast = 1'b0;
                    st_next.late = 1'b0;
                    st_next.rxer = 1'b0;
                    st_next.wd = 1'b0;
                end
            end
            rx_status_pkg::RX_RECV: begin
                // Clearing the enable mid-frame lets the frame finish first
                if (rx_in.rx_er) begin
                    st_next.rxer = 1'b1;
                end
                if (rx_in.col && st_reg.len >= rx_status_pkg::LEN_RUNT) begin
                    st_next.late = 1'b1;
                end
                if (rx_in.vld) begin
                    // Long frames keep flowing: flags only, no truncation
                    st_next.dpush = 1'b1;
                    st_next.dbyte = rx_in.data;
                    if (st_reg.len != rx_status_pkg::LEN_SAT) begin
                        st_next.len = st_reg.len + 14'h0001;
                    end
                    if (st_reg.len == '0) begin
                        st_next.mcast = rx_in.data[0];
                    end
                    if (st_reg.len < rx_status_pkg::LEN_DA && rx_in.data != rx_status_pkg::BYTE_ONES) begin
                        st_next.bcast = 1'b0;
                    end
                    if (st_reg.len == rx_status_pkg::LEN_LT_HI) begin
                        st_next.ltype[15:8] = rx_in.data;
                    end
                    if (st_reg.len == rx_status_pkg::LEN_LT_LO) begin
                        st_next.ltype[7:0] = rx_in.data;
                    end
                    if (st_reg.len >= rx_status_pkg::LEN_WD) begin
                        st_next.wd = 1'b1;
                    end
                end else if (rx_in.eof) begin
                    st_next.fsm = rx_status_pkg::RX_STAT;
                    st_next.crcb = rx_in.crc_bad;
                    st_next.filt = rx_in.filt_fail;
                    st_next.drib = rx_in.dribble;
                    st_next.m10 = rx_in.mode_10m;
                    st_next.bcast = st_reg.bcast && st_reg.len >= rx_status_pkg::LEN_DA;
                end
            end
            rx_status_pkg::RX_STAT: begin
                // Last data byte was pushed a cycle earlier, so status follows it
                if (runt && !st_reg.pbf) begin
                    st_next.drop = 1'b1;
                end else if (st_reg.cnt[2]) begin
                    err_set = 1'b1;
                end else begin
                    push = 1'b1;
                end
                if (st_reg.en) begin
                    st_next.fsm = rx_status_pkg::RX_IDLE;
                end else begin
                    st_next.fsm = rx_status_pkg::RX_HALT;
                    st_next.hirq = 1'b1;
                end
            end
            rx_status_pkg::RX_HALT: begin
                if (st_reg.en) begin
                    st_next.fsm = rx_status_pkg::RX_IDLE;
                end
            end
            default: begin
                st_next.fsm = rx_status_pkg::RX_IDLE;
            end
        endcase

        // Word taken in the status state: the end-of-frame fields only land at the eof edge
        if (st_reg.fsm == rx_status_pkg::RX_STAT) begin
            st_next.sword = sw;
        end

        // Bus data phase: one wait state so read data leaves a flop
        st_next.pend = acc;
        if (acc) begin
            st_next.pwr = hwrite;
            st_next.paddr = haddr[3:0];
        end
        if (st_reg.pend) begin
            st_next.rdata = '0;
            if (st_reg.paddr == rx_status_pkg::ADDR_CTRL) begin
                if (st_reg.pwr) begin
                    st_next.en = hwdata[rx_status_pkg::CTRL_EN];
                    st_next.pbf = hwdata[rx_status_pkg::CTRL_PBF];
                    if (hwdata[rx_status_pkg::CTRL_FLUSH] && st_reg.fsm == rx_status_pkg::RX_HALT) begin
                        st_next.wp = '0;
                        st_next.rp = '0;
                        st_next.cnt = '0;
                    end
                end else begin
                    st_next.rdata[rx_status_pkg::CTRL_EN] = st_reg.en;
                    st_next.rdata[rx_status_pkg::CTRL_PBF] = st_reg.pbf;
                end
            end else if (st_reg.paddr == rx_status_pkg::ADDR_STAT) begin
                if (st_reg.pwr) begin
                    err_clr = hwdata[rx_status_pkg::ST_ERR];
                end else begin
                    st_next.rdata[rx_status_pkg::ST_HALT] = st_reg.fsm == rx_status_pkg::RX_HALT;
                    st_next.rdata[rx_status_pkg::ST_ERR] = st_reg.err;
                    st_next.rdata[rx_status_pkg::ST_CNT_LSB +: 3] = st_reg.cnt;
                end
            end else if (st_reg.paddr == rx_status_pkg::ADDR_SFIFO) begin
                if (!st_reg.pwr) begin
                    if (st_reg.cnt == '0) begin
                        err_set = 1'b1;
                    end else begin
                        pop = 1'b1;
                        st_next.rdata = st_reg.sf[st_reg.rp];
                    end
                end
            end
        end

        // Entry counted only after it is stored whole
        if (push) begin
            st_next.sf[st_reg.wp] = sw;
            st_next.wp = st_reg.wp + 2'h1;
        end
        if (pop) begin
            st_next.rp = st_reg.rp + 2'h1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 3'h1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 3'h1;
        end
        // Set wins over a same-cycle clear; the receiver is never stopped by it
        st_next.err = (st_reg.err && !err_clr) || err_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_RSVD: assert property (st_reg.fsm == rx_status_pkg::RX_STAT |-> (sw & rx_status_pkg::RSVD_MASK) == '0)
        else $error("reserved status bit set");
    AST_LEN: assert property (st_reg.fsm == rx_status_pkg::RX_STAT |-> sw[29:16] == st_reg.len)
        else $error("length field differs from count");
    AST_ES: assert property (st_reg.fsm == rx_status_pkg::RX_STAT |-> sw[15] ==
        (sw[11] | sw[7] | sw[6] | sw[1]))
        else $error("error summary wrong");
    AST_RUNT: assert property (st_reg.fsm == rx_status_pkg::RX_STAT |-> sw[11] ==
        (st_reg.len < rx_status_pkg::LEN_RUNT))
        else $error("runt flag wrong");
    AST_DROP: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && runt && !st_reg.pbf
        |=> data_out.drop && $stable(st_reg.wp))
        else $error("runt not dropped");
    AST_DRIB: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && sw[6] |-> !sw[2])
        else $error("dribble with late collision");
    AST_CRC: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && (sw[11] || sw[4])
        |-> !sw[1])
        else $error("crc bit on invalid frame");
    AST_HALT: assert property (st_reg.fsm != rx_status_pkg::RX_HALT ##1 st_reg.fsm == rx_status_pkg::RX_HALT
        |-> receiver_halted_interrupt ##1 !receiver_halted_interrupt)
        else $error("halt pulse missing");
    AST_UNDER: assert property (st_reg.pend && !st_reg.pwr && st_reg.paddr == rx_status_pkg::ADDR_SFIFO
        && st_reg.cnt == '0 |=> receive_error_flag)
        else $error("underrun not flagged");
    AST_PUSH: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.eof && !rx_in.vld
        |=> !data_out.push)
        else $error("data after status");
    AST_FILT: assert property (st_reg.fsm == rx_status_pkg::RX_STAT
        |-> sw[rx_status_pkg::SB_FILT] == st_reg.filt)
        else $error("filter fail bit wrong");
    AST_BCAST: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.vld
        && st_reg.len < rx_status_pkg::LEN_DA && rx_in.data != rx_status_pkg::BYTE_ONES
        |=> !st_reg.bcast)
        else $error("broadcast kept after other byte");
    AST_LE: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && sw[rx_status_pkg::SB_LE]
        |-> st_reg.ltype <= rx_status_pkg::TYPE_MIN && st_reg.len >= rx_status_pkg::LEN_OVH)
        else $error("length error on type frame");
    AST_MCAST: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.vld && st_reg.len == '0
        |=> st_reg.mcast == $past(rx_in.data[0]))
        else $error("multicast bit not from first byte");
    AST_LONG: assert property (st_reg.fsm == rx_status_pkg::RX_STAT
        |-> sw[rx_status_pkg::SB_LONG] == (st_reg.len > rx_status_pkg::LEN_MAX))
        else $error("too long flag wrong");
    AST_FLOW: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.vld
        |=> data_out.push && data_out.data == $past(rx_in.data))
        else $error("byte not passed on");
    AST_LATE: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.col
        && st_reg.len >= rx_status_pkg::LEN_RUNT |=> st_reg.late)
        else $error("late collision missed");
    AST_TYPE: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && st_reg.len < rx_status_pkg::LEN_HDR
        |-> !sw[rx_status_pkg::SB_TYPE])
        else $error("type bit on short runt");
    AST_WD: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.vld
        && st_reg.len >= rx_status_pkg::LEN_WD |=> st_reg.wd)
        else $error("watchdog missed");
    AST_MII: assert property (st_reg.fsm == rx_status_pkg::RX_RECV && rx_in.rx_er |=> st_reg.rxer)
        else $error("receive error missed");
    AST_FULL: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && !(runt && !st_reg.pbf) && st_reg.cnt[2]
        |=> receive_error_flag && $stable(st_reg.wp))
        else $error("overflow not flagged");
    AST_STORE: assert property (st_reg.fsm == rx_status_pkg::RX_STAT && !(runt && !st_reg.pbf) && !st_reg.cnt[2]
        |=> st_reg.sf[$past(st_reg.wp)] == st_reg.sword)
        else $error("stored entry differs from status word");
endmodule // rx_status

// File: pkg/rx_status_pkg.sv
// Constants and types for the receive status block
// Summary of operation
// - Reserved status bits 31,14,9:8,0 read zero
// - Bit 30 flags address filter failure
// - Bits 29:16 carry frame length in bytes
// - Bit 15 is OR of bits 11,7,6,1
// - Bit 13 flags broadcast destination
// - Bit 12 flags length field mismatch
// - Bit 11 flags frame under 64 bytes
// - Runts delivered only when pass-bad is set
// - Bit 10 flags multicast destination
// - Bit 7 flags over 1518 bytes, no truncation
// - Bit 6 flags collision after the window
// - Bit 5 set when type above 1500
// - Bit 4 flags watchdog beyond 2048 bytes
// - Bit 3 flags receive error during frame
// - Bit 2 dribble rule, never with bit 6
// - Bit 1 CRC or receive error, masked
// - One halt pulse once receiver stops
// - Receive error flag never stops reception
// - Error flag on FIFO underrun or overflow
// - Status pushed after all frame data
package rx_status_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_SFIFO = 4'h8;
    localparam int CTRL_EN = 0;
    localparam int CTRL_FLUSH = 1;
    localparam int CTRL_PBF = 16;
    localparam int ST_HALT = 0;
    localparam int ST_ERR = 1;
    localparam int ST_CNT_LSB = 8;
    localparam int SB_FILT = 30;
    localparam int SB_LEN_LSB = 16;
    localparam int SB_ES = 15;
    localparam int SB_BC = 13;
    localparam int SB_LE = 12;
    localparam int SB_RUNT = 11;
    localparam int SB_MC = 10;
    localparam int SB_LONG = 7;
    localparam int SB_LATE = 6;
    localparam int SB_TYPE = 5;
    localparam int SB_WD = 4;
    localparam int SB_MII = 3;
    localparam int SB_DRIB = 2;
    localparam int SB_CRC = 1;
    localparam logic [31:0] RSVD_MASK = 32'h8000_4301;
    localparam logic [13:0] LEN_RUNT = 14'h0040;
    localparam logic [13:0] LEN_MAX = 14'h05EE;
    localparam logic [13:0] LEN_WD = 14'h0800;
    localparam logic [13:0] LEN_HDR = 14'h000E;
    localparam logic [13:0] LEN_OVH = 14'h0012;
    localparam logic [13:0] LEN_LT_HI = 14'h000C;
    localparam logic [13:0] LEN_LT_LO = 14'h000D;
    localparam logic [13:0] LEN_DA = 14'h0006;
    localparam logic [13:0] LEN_SAT = 14'h3FFF;
    localparam logic [15:0] TYPE_MIN = 16'h05DC;
    localparam logic [2:0] DRIB_MII = 3'h4;
    localparam logic [2:0] DRIB_10M = 3'h3;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_RECV = 2'h1,
        RX_STAT = 2'h3,
        RX_HALT = 2'h2
    } rx_state_e;
    typedef struct packed {
        logic sof;
        logic vld;
        logic [7:0] data;
        logic eof;
        logic rx_er;
        logic col;
        logic crc_bad;
        logic filt_fail;
        logic [2:0] dribble;
        logic mode_10m;
    } rx_in_s;
    typedef struct packed {
        logic push;
        logic [7:0] data;
        logic drop;
    } data_out_s;
endpackage

// File: verification/frame_src.sv
// Frame source that feeds the receive byte stream of the status block
`timescale 1ns/1ps
module frame_src (
    input wire logic hclk,
    output rx_status_pkg::rx_in_s rx_in
);
    initial rx_in = '0;
    // Bytes 0..5 carry the address, bytes 12..13 the length/type field
    task send(input logic [13:0] len, input logic [7:0] b0, input logic bc, input logic [15:0] lt,
              input logic rxer, input logic col, input logic crc, input logic filt,
              input logic [2:0] drib, input logic m10);
        logic [7:0] b;
        @(posedge hclk);
        rx_in.sof <= 1'b1;
        @(posedge hclk);
        rx_in.sof <= 1'b0;
        for (int i = 0; i < len; i++) begin
            b = 8'(i);
            if (i == 0) b = b0;
            else if (i < 6 && bc) b = 8'hFF;
            else if (i == 12) b = lt[15:8];
            else if (i == 13) b = lt[7:0];
            rx_in.vld <= 1'b1;
            rx_in.data <= b;
            rx_in.rx_er <= rxer && i == 1;
            rx_in.col <= col && i == len - 1;
            @(posedge hclk);
        end
        // Idle data lines show the inverse so a stale byte is never mistaken
        rx_in.vld <= 1'b0;
        rx_in.data <= ~b;
        rx_in.rx_er <= 1'b0;
        rx_in.col <= 1'b0;
        rx_in.eof <= 1'b1;
        rx_in.crc_bad <= crc;
        rx_in.filt_fail <= filt;
        rx_in.dribble <= drib;
        rx_in.mode_10m <= m10;
        @(posedge hclk);
        rx_in.eof <= 1'b0;
        rx_in.crc_bad <= 1'b0;
        rx_in.filt_fail <= 1'b0;
        rx_in.dribble <= 3'h0;
        repeat (4) @(posedge hclk);
    endtask
endmodule // frame_src

// File: verification/test_rx_status.sv
// Self-checking bench for the receive status block
`timescale 1ns/1ps
module test_rx_status;
    typedef struct packed {
        logic [13:0] len; logic [7:0] b0; logic bc; logic [15:0] lt;
        logic rxer; logic col; logic crc; logic filt; logic [2:0] drib; logic m10;
    } frame_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    rx_status_pkg::rx_in_s rx_in;
    logic data_underrun = 1'b0;
    rx_status_pkg::data_out_s data_out;
    logic halt_irq;
    logic err_flag;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_halt = 0;
    int n_push = 0;
    int n_drop = 0;
    logic [31:0] rd;
    logic [7:0] first_byte = 8'h00;
    frame_s tbl [8];
    always #5 hclk = ~hclk;
    rx_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in), .data_underrun(data_underrun),
        .data_out(data_out), .receiver_halted_interrupt(halt_irq), .receive_error_flag(err_flag));
    frame_src SRC (.hclk(hclk), .rx_in(rx_in));
    always @(posedge hclk) begin
        if (halt_irq === 1'b1) n_halt++;
        if (data_out.push === 1'b1 && n_push == 0) first_byte = data_out.data;
        if (data_out.push === 1'b1) n_push++;
        if (data_out.drop === 1'b1) n_drop++;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded wait for hready; data is taken at the edge that sees it high
    task wait_rdy(output logic [31:0] d);
        int k;
        k = 0;
        #1;
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
            #1;
            k++;
            if (k > 20) begin
                n_mismatch++;
                test_done;
            end
        end
        d = hrdata;
        @(posedge hclk);
    endtask
    task ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        logic [31:0] x;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= rx_status_pkg::HTRANS_NONSEQ;
        haddr <= {28'h0000000, a};
        hwrite <= wr;
        hsize <= rx_status_pkg::HSIZE_WORD;
        wait_rdy(x);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(d);
    endtask
    task send(input frame_s f);
        SRC.send(f.len, f.b0, f.bc, f.lt, f.rxer, f.col, f.crc, f.filt, f.drib, f.m10);
    endtask
    task stat(input logic [31:0] exp);
        ahb(1'b0, rx_status_pkg::ADDR_STAT, 32'h0000_0000, rd);
        chk(rd & 32'h0000_0703, exp);
    endtask
    function automatic logic [31:0] expect_word(frame_s f);
        logic runt;
        logic late;
        logic wd;
        logic [31:0] w;
        runt = f.len < 14'h0040;
        late = f.col && !runt;
        wd = f.len > 14'h0800;
        w = {2'h0, f.len, 16'h0000};
        w[30] = f.filt;
        w[13] = f.bc;
        w[10] = f.b0[0];
        w[11] = runt;
        w[7] = f.len > 14'h05EE;
        w[6] = late;
        w[5] = f.len >= 14'h000E && f.lt > 16'h05DC;
        w[4] = wd;
        w[3] = f.rxer;
        w[2] = !late && (f.m10 ? f.drib >= 3'h3 : f.drib == 3'h4);
        w[1] = (f.crc || f.rxer) && !runt && !late && !wd;
        w[12] = f.lt <= 16'h05DC && f.len >= 14'h0012 && f.lt != {2'h0, f.len} - 16'h0012;
        w[15] = w[11] | w[7] | w[6] | w[1];
        return w;
    endfunction
    initial begin
        tbl[0] = {14'h0040, 8'h01, 1'b0, 16'h002E, 4'h1, 3'h4, 1'b0};
        tbl[1] = {14'h0064, 8'hFF, 1'b1, 16'h0800, 4'h2, 3'h3, 1'b1};
        tbl[2] = {14'h0046, 8'h00, 1'b0, 16'h000A, 4'h8, 3'h3, 1'b0};
        tbl[3] = {14'h05EF, 8'h00, 1'b0, 16'h05DD, 4'h6, 3'h4, 1'b0};
        tbl[4] = {14'h0834, 8'h00, 1'b0, 16'h0000, 4'h2, 3'h0, 1'b0};
        tbl[5] = {14'h0014, 8'h00, 1'b0, 16'h0800, 4'h2, 3'h0, 1'b0};
        tbl[6] = {14'h000A, 8'h00, 1'b0, 16'h0800, 4'h0, 3'h0, 1'b0};
        tbl[7] = {14'h001E, 8'h00, 1'b0, 16'h0000, 4'h0, 3'h0, 1'b0};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        stat(32'h0000_0001);
        chk(32'(n_halt), 32'h0000_0001);
        ahb(1'b1, rx_status_pkg::ADDR_CTRL, 32'h0001_0001, rd);
        for (int i = 0; i < 7; i++) begin
            n_push = 0;
            send(tbl[i]);
            stat(32'h0000_0100);
            ahb(1'b0, rx_status_pkg::ADDR_SFIFO, 32'h0000_0000, rd);
            chk(rd, expect_word(tbl[i]));
            chk(32'(n_push), 32'(tbl[i].len));
            chk({24'h0, first_byte}, {24'h0, tbl[i].b0});
        end
        // Without pass-bad a runt is dropped and never queued
        ahb(1'b1, rx_status_pkg::ADDR_CTRL, 32'h0000_0001, rd);
        send(tbl[7]);
        stat(32'h0000_0000);
        chk(32'(n_drop), 32'h0000_0001);
        for (int i = 0; i < 5; i++) send(tbl[0]);
        stat(32'h0000_0402);
        ahb(1'b1, rx_status_pkg::ADDR_STAT, 32'h0000_0002, rd);
        chk({31'h0, err_flag}, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, rx_status_pkg::ADDR_SFIFO, 32'h0000_0000, rd);
            chk(rd, expect_word(tbl[0]));
        end
        ahb(1'b0, rx_status_pkg::ADDR_SFIFO, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err_flag}, 32'h0000_0001);
        ahb(1'b1, rx_status_pkg::ADDR_STAT, 32'h0000_0002, rd);
        @(posedge hclk);
        data_underrun <= 1'b1;
        @(posedge hclk);
        data_underrun <= 1'b0;
        send(tbl[1]);
        stat(32'h0000_0102);
        // Halt with an entry queued, then flush and restart
        ahb(1'b1, rx_status_pkg::ADDR_CTRL, 32'h0000_0000, rd);
        repeat (4) @(posedge hclk);
        chk(32'(n_halt), 32'h0000_0002);
        send(tbl[0]);
        stat(32'h0000_0103);
        ahb(1'b1, rx_status_pkg::ADDR_CTRL, 32'h0000_0002, rd);
        stat(32'h0000_0003);
        ahb(1'b1, rx_status_pkg::ADDR_CTRL, 32'h0000_0001, rd);
        send(tbl[2]);
        ahb(1'b0, rx_status_pkg::ADDR_SFIFO, 32'h0000_0000, rd);
        chk(rd, expect_word(tbl[2]));
        ahb(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 4'hC, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        test_done;
    end
endmodule // test_rx_status
